// ==== rtl/ehci_intr_consts.svh ====
// offsets, field positions, reset values and timing counts
// assumes inclusion by the interrupt-enable / frame-index block
`ifndef EHCI_INTR_CONSTS_SVH
`define EHCI_INTR_CONSTS_SVH
`define INTR_EN_OFFSET   8'h28
`define FRAME_IDX_OFFSET 8'h2c
`define INTR_EN_RESET    6'h00
`define FRAME_IDX_RESET  14'h0000
`define EN_ASYNC_BIT     5
`define EN_SYSERR_BIT    4
`define EN_ROLLOVER_BIT  3
`define EN_PORT_BIT      2
`define EN_XERR_BIT      1
`define EN_XDONE_BIT     0
`define DEFERRED_MASK    6'h23
`define IMMEDIATE_MASK   6'h1c
`define FULL_WORD_BE     4'hf
`define LIST_1024        2'h0
`define LIST_512         2'h1
`define LIST_256         2'h2
`define MICROFRAME_NS    125000
`define CLK_PERIOD_NS    5
`endif

// ==== rtl/ehci_intr_enable_frame_index.sv ====
// interrupt-enable gating and microframe index counter
// assumes status levels, halt state, list size and threshold tick
// come synchronous to ref_clk from the neighbouring command logic
//
// Behaviour
// - interrupt when enabled status is active
// - disabled enables gate output only, status untouched
// - bit 5 async advance, at threshold
// - bit 4 system error, immediate
// - bit 3 rollover, immediate
// - bit 2 port change, immediate
// - bit 1 transaction error, at threshold
// - bit 0 transfer complete, at threshold
// - index advances once per 125 us microframe
// - index in bits 13:0, rest read zero
// - frame number is index bits 13:3
// - bits N:3 select periodic list entry
// - list size sets N as 12, 11, 10
// - index writes change sent frame number
// - rollover flag set when list index wraps
`timescale 1ns/1ps
`include "ehci_intr_consts.svh"

module ehci_intr_enable_frame_index
  import ehci_intr_pkg::*;
#(
  parameter int unsigned MICROFRAME_CYCLES =
    `MICROFRAME_NS / `CLK_PERIOD_NS
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [3:0]    reg_be,
  input  wire logic [31:0]   reg_wdata,
  output logic      [31:0]   reg_rdata,
  output logic               reg_rvalid,
  input  wire irq_vec_type   status_flags,
  input  wire logic          halted_flag,
  input  wire logic [1:0]    list_size_sel,
  input  wire logic          threshold_tick,
  output logic               host_irq,
  output logic               rollover_set,
  output logic      [10:0]   sof_frame_num,
  output list_idx_type       list_index
);

  localparam tick_cnt_type LAST_TICK =
    tick_cnt_type'(MICROFRAME_CYCLES - 1);

  // highest index bit that still belongs to the list index, plus one
  function automatic logic [3:0] wrap_bit(input logic [1:0] sel);
    case (sel)
      `LIST_512: wrap_bit = 4'hc;
      `LIST_256: wrap_bit = 4'hb;
      default:   wrap_bit = 4'hd;
    endcase
  endfunction

  function automatic list_idx_type index_mask(input logic [1:0] sel);
    case (sel)
      `LIST_512: index_mask = 10'h1ff;
      `LIST_256: index_mask = 10'h0ff;
      default:   index_mask = 10'h3ff;
    endcase
  endfunction

  irq_vec_type   intr_enable;
  irq_vec_type   next_intr_enable;
  frame_idx_type frame_index;
  frame_idx_type next_frame_index;
  tick_cnt_type  tick_cnt;
  tick_cnt_type  next_tick_cnt;
  irq_vec_type   defer_hold;
  irq_vec_type   next_defer_hold;
  logic          next_host_irq;
  logic          next_rollover_set;
  logic [10:0]   next_sof_frame_num;
  list_idx_type  next_list_index;
  logic [31:0]   next_reg_rdata;
  logic          next_reg_rvalid;
  logic          en_wr;
  logic          idx_load;
  logic          idx_step;
  irq_vec_type   active;
  frame_idx_type stepped;

  // register writes
  always_comb begin
    en_wr = reg_wr && (reg_addr == `INTR_EN_OFFSET) && reg_be[0];
    // partial or running writes to the index are dropped
    idx_load = reg_wr && (reg_addr == `FRAME_IDX_OFFSET) &&
               (reg_be == `FULL_WORD_BE) && halted_flag;
    next_intr_enable = intr_enable;
    if (en_wr) begin
      // reserved enable bits are not stored and read zero
      next_intr_enable = reg_wdata[5:0];
    end
  end

  // microframe timer and index
  always_comb begin
    stepped = frame_index + 14'h0001;
    idx_step = !halted_flag && !idx_load && (tick_cnt == LAST_TICK);
    next_tick_cnt = tick_cnt;
    next_frame_index = frame_index;
    next_rollover_set = 1'b0;
    if (idx_load || halted_flag) begin
      next_tick_cnt = '0;
    end else if (idx_step) begin
      next_tick_cnt = '0;
    end else begin
      next_tick_cnt = tick_cnt + 15'h0001;
    end
    if (idx_load) begin
      next_frame_index = reg_wdata[13:0];
    end else if (idx_step) begin
      next_frame_index = stepped;
      next_rollover_set = stepped[wrap_bit(list_size_sel)] !=
                          frame_index[wrap_bit(list_size_sel)];
    end
    next_sof_frame_num = next_frame_index[13:3];
    next_list_index = next_frame_index[12:3] &
                      index_mask(list_size_sel);
  end

  // interrupt gating
  always_comb begin
    active = status_flags & intr_enable;
    // deferred sources latch at a threshold tick, drop with status
    next_defer_hold = active & `DEFERRED_MASK &
                      (defer_hold | {6{threshold_tick}});
    next_host_irq = |(active & `IMMEDIATE_MASK) ||
                    |next_defer_hold;
  end

  // register reads
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `INTR_EN_OFFSET:   next_reg_rdata = {26'h0, intr_enable};
        `FRAME_IDX_OFFSET: next_reg_rdata = {18'h0, frame_index};
        default:           next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intr_enable   <= `INTR_EN_RESET;
      frame_index   <= `FRAME_IDX_RESET;
      tick_cnt      <= '0;
      defer_hold    <= '0;
      host_irq      <= 1'b0;
      rollover_set  <= 1'b0;
      sof_frame_num <= '0;
      list_index    <= '0;
      reg_rdata     <= '0;
      reg_rvalid    <= 1'b0;
    end else begin
      intr_enable   <= next_intr_enable;
      frame_index   <= next_frame_index;
      tick_cnt      <= next_tick_cnt;
      defer_hold    <= next_defer_hold;
      host_irq      <= next_host_irq;
      rollover_set  <= next_rollover_set;
      sof_frame_num <= next_sof_frame_num;
      list_index    <= next_list_index;
      reg_rdata     <= next_reg_rdata;
      reg_rvalid    <= next_reg_rvalid;
    end
  end

  no_enable_quiet_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (status_flags & intr_enable) == 6'h00 |=> !host_irq)
    else $error("interrupt raised with no enabled status");

  masked_source_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (status_flags & ~intr_enable) != 6'h00 &&
    (status_flags & intr_enable) == 6'h00 |=> !host_irq)
    else $error("disabled status leaked to interrupt");

  async_deferred_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    status_flags[5] && intr_enable[5] && threshold_tick
    ##1 status_flags[5] && intr_enable[5] |-> host_irq)
    else $error("async advance interrupt missing after threshold");

  syserr_immediate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    status_flags[4] && intr_enable[4] |=> host_irq)
    else $error("system error interrupt not immediate");

  rollover_immediate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    status_flags[3] && intr_enable[3] |=> host_irq)
    else $error("rollover interrupt not immediate");

  port_immediate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    status_flags[2] && intr_enable[2] |=> host_irq)
    else $error("port change interrupt not immediate");

  xerr_wait_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (status_flags & intr_enable) == 6'h02 && defer_hold == 6'h00 &&
    !threshold_tick |=> !host_irq)
    else $error("transaction error fired before threshold");

  xdone_deferred_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    status_flags[0] && intr_enable[0] && threshold_tick
    |=> defer_hold[0] && host_irq)
    else $error("transfer complete interrupt missing at threshold");

  deferred_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (status_flags & intr_enable & `DEFERRED_MASK) == 6'h00
    |=> defer_hold == 6'h00)
    else $error("deferred interrupt held after its source dropped");

  threshold_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !threshold_tick |=> (defer_hold & ~$past(defer_hold)) == 6'h00)
    else $error("deferred interrupt latched without threshold tick");

  enable_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == `INTR_EN_OFFSET && reg_be[0]
    |=> intr_enable == $past(reg_wdata[5:0]))
    else $error("enable write not applied");

  enable_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(reg_wr && reg_addr == `INTR_EN_OFFSET && reg_be[0])
    |=> $stable(intr_enable))
    else $error("enable bits changed without a write");

  enable_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `INTR_EN_OFFSET
    |=> reg_rvalid && reg_rdata == {26'h0, $past(intr_enable)})
    else $error("enable read wrong");

  reset_clear_a: assert property (
    @(posedge ref_clk)
    rst |=> !host_irq && !rollover_set && !reg_rvalid &&
    frame_index == `FRAME_IDX_RESET && intr_enable == `INTR_EN_RESET)
    else $error("state not cleared by reset");

  index_step_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_step |=> frame_index == $past(frame_index) + 14'h0001
    ##1 frame_index == $past(frame_index))
    else $error("frame index step wrong");

  index_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !idx_step && !idx_load |=> $stable(frame_index))
    else $error("frame index moved between microframes");

  index_read_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `FRAME_IDX_OFFSET
    |=> reg_rvalid && reg_rdata == {18'h0, $past(frame_index)})
    else $error("frame index read wrong");

  sof_number_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    sof_frame_num == frame_index[13:3])
    else $error("frame number not index bits 13 to 3");

  list_select_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $stable(list_size_sel) |->
    list_index == (frame_index[12:3] & index_mask(list_size_sel)))
    else $error("list index does not follow size setting");

  list_rest_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_step && frame_index[2:0] != 3'h7 && $stable(list_size_sel)
    |=> $stable(list_index))
    else $error("list entry left before eight microframes");

  index_write_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_load |=> frame_index == $past(reg_wdata[13:0]) &&
    sof_frame_num == $past(reg_wdata[13:3]))
    else $error("index write not applied");

  write_refused_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == `FRAME_IDX_OFFSET && !idx_step &&
    (!halted_flag || reg_be != `FULL_WORD_BE) |=> $stable(frame_index))
    else $error("refused index write changed the index");

  rollover_pulse_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_step && frame_index[12:0] == 13'h1fff &&
    list_size_sel == `LIST_1024 |=> rollover_set ##1 !rollover_set)
    else $error("rollover pulse missing");

  rollover_512_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_step && frame_index[11:0] == 12'hfff &&
    list_size_sel == `LIST_512 |=> rollover_set)
    else $error("rollover pulse missing at 512 entries");

  rollover_256_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idx_step && frame_index[10:0] == 11'h7ff &&
    list_size_sel == `LIST_256 |=> rollover_set)
    else $error("rollover pulse missing at 256 entries");

  rollover_only_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !idx_step || frame_index[10:0] != 11'h7ff |=> !rollover_set)
    else $error("rollover pulse without a list wrap");

endmodule

// ==== rtl/ehci_intr_pkg.sv ====
// types shared by the interrupt-enable / frame-index block
// assumes nothing of its surroundings
package ehci_intr_pkg;
  typedef logic [5:0]  irq_vec_type;
  typedef logic [13:0] frame_idx_type;
  typedef logic [9:0]  list_idx_type;
  typedef logic [14:0] tick_cnt_type;
endpackage

// ==== tb/testbench.sv ====
// self-checking bench for the interrupt-enable / frame-index block
// assumes the rtl package, header and block compile ahead of this file
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module testbench;
  import ehci_intr_pkg::*;
  localparam int M = 8;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    reg_addr = 8'h00;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [3:0]    reg_be = 4'h0;
  logic [31:0]   reg_wdata = 32'h0;
  logic [31:0]   reg_rdata;
  logic          reg_rvalid;
  irq_vec_type   status_flags = 6'h00;
  logic          halted_flag = 1'b1;
  logic [1:0]    list_size_sel = 2'h0;
  logic          threshold_tick = 1'b0;
  logic          host_irq;
  logic          rollover_set;
  logic [10:0]   sof_frame_num;
  list_idx_type  list_index;
  logic [10:0]   sof_e;
  logic          imm;
  int            err_count = 0;
  int            total_checks = 0;

  ehci_intr_enable_frame_index #(.MICROFRAME_CYCLES(M)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .status_flags(status_flags), .halted_flag(halted_flag),
    .list_size_sel(list_size_sel), .threshold_tick(threshold_tick),
    .host_irq(host_irq), .rollover_set(rollover_set),
    .sof_frame_num(sof_frame_num), .list_index(list_index));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
    step();
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    step();
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    `CHK(n, 1'b1, reg_rvalid)
    `CHK(n, e, reg_rdata)
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(8'h28, 32'h0, "en_reset");
    rd(8'h2c, 32'h0, "idx_reset");
    rd(8'h30, 32'h0, "unmapped");
    wr(8'h28, 32'h3f, 4'he);
    rd(8'h28, 32'h0, "en_partial");
    wr(8'h28, 32'hffffffff, 4'hf);
    rd(8'h28, 32'h3f, "en_reserved");
    // one source at a time: immediate ones need no threshold tick
    for (int i = 0; i < 6; i++) begin
      imm = (i >= 2 && i <= 4);
      status_flags = irq_vec_type'(1 << i);
      step();
      `CHK("irq_now", imm, host_irq)
      step(2);
      `CHK("irq_wait", imm, host_irq)
      threshold_tick = 1'b1;
      step();
      threshold_tick = 1'b0;
      step();
      `CHK("irq_tick", 1'b1, host_irq)
      wr(8'h28, 32'h0, 4'hf);
      step();
      `CHK("irq_masked", 1'b0, host_irq)
      status_flags = 6'h00;
      wr(8'h28, 32'h3f, 4'hf);
    end
    // each list size: masking, wrap pulse, eight steps per entry
    for (int s = 0; s < 3; s++) begin
      list_size_sel = 2'(s);
      wr(8'h2c, 32'h3ff8, 4'hf);
      step();
      `CHK("sof_write", 11'h7ff, sof_frame_num)
      `CHK("list_mask", 10'h3ff >> s, list_index)
      wr(8'h2c, 32'h1fff >> s, 4'h3);
      rd(8'h2c, 32'h3ff8, "idx_partial");
      wr(8'h2c, 32'h1fff >> s, 4'hf);
      halted_flag = 1'b0;
      for (int k = 0; k < 4 * M && rollover_set !== 1'b1; k++) step();
      sof_e = 11'(32'h2000 >> (s + 3));
      `CHK("roll_set", 1'b1, rollover_set)
      `CHK("sof_wrap", sof_e, sof_frame_num)
      `CHK("list_wrap", 10'h000, list_index)
      step();
      `CHK("roll_pulse", 1'b0, rollover_set)
      step(8 * M - 2);
      `CHK("sof_hold", sof_e, sof_frame_num)
      step();
      `CHK("sof_next", sof_e + 11'h001, sof_frame_num)
      halted_flag = 1'b1;
      rd(8'h2c, (32'h2000 >> s) + 32'h8, "idx_run");
    end
    // reset again while halted: enable and index must return to zero
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    rd(8'h28, 32'h0, "en_rerun");
    rd(8'h2c, 32'h0, "idx_rerun");
    complete_run();
  end
endmodule
